// >>> verilog/ici_pkg.sv
// package: constants and carrier types of the instrument command interpreter
`default_nettype none
package ici_pkg;
  // clock rate and idle time before sleep
  localparam longint unsigned CLK_HZ        = 64'd200000000;
  localparam longint unsigned IDLE_TIME_MIN = 64'd2;
  localparam longint unsigned IDLE_CYC_DEF  = IDLE_TIME_MIN * 64'd60 * CLK_HZ;
  localparam int unsigned     TICKS_PER_S   = 32'(CLK_HZ);
  localparam logic [5:0]      LINE_MAX_DEF  = 6'h20;
  localparam int unsigned     PTR_W         = 24;
  // characters
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_YES   = 8'h59;
  localparam logic [7:0] CH_NO    = 8'h4E;
  localparam logic [7:0] CH_ERR   = 8'h3F;
  localparam logic [7:0] RPL_CFG  = 8'h43;
  localparam logic [7:0] RPL_STAT = 8'h53;
  localparam logic [7:0] RPL_COEF = 8'h4B;
  localparam logic [7:0] RPL_EVT  = 8'h45;
  localparam logic [7:0] RPL_HW   = 8'h48;
  // acquisition modes and argument limits
  localparam logic [1:0]  MODE_SINGLE   = 2'h1;
  localparam logic [1:0]  MODE_INTERVAL = 2'h2;
  localparam logic [1:0]  MODE_CONT     = 2'h3;
  localparam logic [1:0]  FMT_MAX       = 2'h3;
  localparam logic [31:0] INTERVAL_MIN  = 32'h6;
  localparam logic [31:0] INTERVAL_MAX  = 32'h5460;
  localparam logic [4:0]  DATE_DIGITS   = 5'hE;
  localparam logic [3:0]  BAUD_CNT      = 4'h9;
  localparam logic [31:0] BAUD_TAB [9] = '{32'h258, 32'h4B0, 32'h960,
    32'h12C0, 32'h2580, 32'h4B00, 32'h9600, 32'hE100, 32'h1C200};
  // register offsets
  localparam logic [7:0] REG_CFG   = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_PTR   = 8'h08;
  localparam logic [7:0] REG_TALLY = 8'h0C;
  localparam logic [7:0] REG_PRESS = 8'h10;
  // reset values
  localparam logic [1:0]  MODE_RST     = 2'h1;
  localparam logic [14:0] INTERVAL_RST = 15'h6;
  localparam logic [3:0]  BAUD_RST     = 4'h4;
  localparam logic [1:0]  FMT_RST      = 2'h1;
  localparam logic        STORE_RST    = 1'h1;
  // keywords: length then last four upper-case characters
  typedef logic [37:0] ici_kw_t;
  localparam ici_kw_t KW_ACQ_MODE    = {6'h0A, 32'h4D4F4445};
  localparam ici_kw_t KW_INTERVAL    = {6'h0E, 32'h5256414C};
  localparam ici_kw_t KW_LAST_REC    = {6'h0C, 32'h4D424552};
  localparam ici_kw_t KW_POWER_ON    = {6'h07, 32'h4F52554E};
  localparam ici_kw_t KW_LOG_RESET   = {6'h0B, 32'h47494E47};
  localparam ici_kw_t KW_CLOCK_SET   = {6'h08, 32'h54494D45};
  localparam ici_kw_t KW_SPEED       = {6'h08, 32'h52415445};
  localparam ici_kw_t KW_SESSION_END = {6'h02, 32'h00005153};
  localparam ici_kw_t KW_STORE       = {6'h09, 32'h44415441};
  localparam ici_kw_t KW_ENCODING    = {6'h0C, 32'h524D4154};
  localparam ici_kw_t KW_TIME_F      = {6'h0A, 32'h54494D45};
  localparam ici_kw_t KW_SAL_F       = {6'h09, 32'h5453414C};
  localparam ici_kw_t KW_SOUND_F     = {6'h08, 32'h55545356};
  localparam ici_kw_t KW_DENS_F      = {6'h0D, 32'h53495459};
  localparam ici_kw_t KW_FIX_PRESS   = {6'h11, 32'h53555245};
  localparam ici_kw_t KW_CFG_Q       = {6'h05, 32'h45544344};
  localparam ici_kw_t KW_STATE_Q     = {6'h05, 32'h45545344};
  localparam ici_kw_t KW_COEF_Q      = {6'h05, 32'h45544343};
  localparam ici_kw_t KW_TALLY_Q     = {6'h05, 32'h45544543};
  localparam ici_kw_t KW_TALLY_CLR   = {6'h07, 32'h45544543};
  localparam ici_kw_t KW_HW_Q        = {6'h05, 32'h45544844};
  localparam ici_kw_t KW_STAT_DUMP   = {6'h02, 32'h00004453};
  localparam ici_kw_t KW_COEF_DUMP   = {6'h02, 32'h00004443};
  localparam ici_kw_t KW_RUN         = {6'h05, 32'h54415254};
  localparam ici_kw_t KW_HALT        = {6'h04, 32'h53544F50};

  typedef enum logic [1:0] {SMP_IDLE, SMP_BUSY, SMP_WAIT} ici_smp_t;
  typedef struct packed {
    logic [14:0] intervalS;
    logic [3:0]  baud;
    logic        densF;
    logic        svF;
    logic        salF;
    logic        timeF;
    logic        store;
    logic        pwrOnRun;
    logic [1:0]  fmt;
    logic [1:0]  mode;
  } ici_cfg_t;
  typedef struct packed {
    logic [5:0]  lineLen;
    logic [5:0]  keyLen;
    logic [31:0] keyTail;
    logic        seenEq;
    logic [4:0]  digits;
    logic        seenYn;
    logic        yes;
    logic        bad;
    logic        ovf;
    logic [31:0] argDec;
    logic [55:0] argBcd;
  } ici_line_t;
endpackage
`default_nettype wire

// >>> verilog/ici_top.sv
// module: serial line command interpreter with its register slave
// Contract
// R1: mode 1 takes exactly one sample per sample command
// R2: mode 2 repeats samples spaced by the programmed interval
// R3: mode 3 samples back to back without waiting
// R4: power-on flag Y starts sampling in the current mode after reset
// R5: power-on flag N stays idle after reset until commanded
// R6: log pointer reset command frees the whole memory; else records append
// R7: keywords are case-insensitive; a line acts only on its terminator
// R8: host sends a terminator to wake a sleeping device
// R9: two idle minutes after a command put the device to sleep
// R10: bad or unknown lines send an error character, nothing executes
// R11: speed command takes only the nine listed rates; default 9600
// R12: clock-set takes fourteen digits mmddyyyyhhmmss into the clock
// R13: session end command sleeps at once
// R14: store flag Y writes each sample to memory; N writes none
// R15: last record index command sets the pointer; zero equals reset
// R16: encoding selector 0 to 3 picks output encoding
// R17: time field flag adds or omits date and time
// R18: salinity field flag adds or omits salinity
// R19: sound speed field flag adds or omits sound speed
// R20: density field flag adds or omits density
// R21: fixed pressure value is stored for pressureless calculation
// R22: queries answer; a separate command clears the event tally
// R23: carriage return ends a line; overlong lines are discarded
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ici_top #(
  parameter longint unsigned IDLE_CYC  = ici_pkg::IDLE_CYC_DEF,
  parameter int unsigned     TICKS     = ici_pkg::TICKS_PER_S,
  parameter logic [5:0]      LINE_MAX  = ici_pkg::LINE_MAX_DEF,
  parameter logic            AUTO_RST  = 1'b0
) (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire logic                     clkEn,
  input  wire logic                     rxValid,
  input  wire logic [7:0]               rxData,
  output logic                          txValid,
  output logic [7:0]                    txData,
  input  wire logic                     txReady,
  output logic                          sampleReq,
  input  wire logic                     sampleDone,
  output logic                          logWrite,
  output logic [ici_pkg::PTR_W-1:0]     logAddr,
  output logic                          rtcLoad,
  output logic [55:0]                   rtcValue,
  output ici_pkg::ici_cfg_t             cfgOut,
  output logic [31:0]                   refPressure,
  output logic                          awake,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata
);
  typedef struct packed {
    ici_pkg::ici_line_t          line;
    ici_pkg::ici_cfg_t           cfg;
    ici_pkg::ici_smp_t           smp;
    logic                        awake;
    logic                        booted;
    logic [35:0]                 idleCnt;
    logic [31:0]                 tick;
    logic [14:0]                 secs;
    logic [ici_pkg::PTR_W-1:0]   ptr;
    logic [ici_pkg::PTR_W-1:0]   logAddr;
    logic                        logWr;
    logic                        smpReq;
    logic                        rtcLoad;
    logic [55:0]                 rtc;
    logic [31:0]                 refP;
    logic [15:0]                 tally;
    logic                        txV;
    logic [7:0]                  txD;
    logic                        busRdy;
    logic                        wrPend;
    logic [7:0]                  wrAddr;
    logic [31:0]                 rdata;
  } ici_state_t;

  localparam ici_pkg::ici_cfg_t CFG_RST = '{intervalS: ici_pkg::INTERVAL_RST,
    baud: ici_pkg::BAUD_RST, fmt: ici_pkg::FMT_RST, mode: ici_pkg::MODE_RST,
    store: ici_pkg::STORE_RST, pwrOnRun: AUTO_RST, default: 1'b0};
  localparam ici_state_t ST_RST = '{cfg: CFG_RST, smp: ici_pkg::SMP_IDLE,
    busRdy: 1'b1, default: '0};

  logic [1:0]        rstSync;
  logic              rstN;
  ici_state_t        s;
  ici_state_t        n;
  logic [7:0]        rxUp;
  logic              lineEnd;
  ici_pkg::ici_kw_t  lineKey;
  logic              execErr;
  logic              smpTaken;

  // reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // upper-case fold and line events
  assign rxUp = (rxData >= 8'h61 && rxData <= 8'h7A) ? rxData - 8'h20 : rxData; // R7
  assign lineEnd = rxValid && s.awake && rxUp == ici_pkg::CH_CR
                   && s.line.lineLen != 6'h0 && !s.line.ovf;
  assign lineKey = {s.line.keyLen, s.line.keyTail};
  assign smpTaken = s.smp == ici_pkg::SMP_BUSY && sampleDone;

  // next-state logic
  always_comb begin
    logic       numOk;
    logic       ynOk;
    logic       bare;
    logic       hit;
    logic [3:0] bc;
    logic [7:0] rpl;
    ici_pkg::ici_cfg_t wc;
    n = s;
    execErr = 1'b0;
    rpl = 8'h0;
    hit = 1'b0;
    bc = 4'h0;
    wc = ici_pkg::ici_cfg_t'(hwdata[28:0]);
    numOk = s.line.seenEq && s.line.digits != 5'h0 && !s.line.seenYn && !s.line.bad;
    ynOk = s.line.seenEq && s.line.digits == 5'h0 && s.line.seenYn && !s.line.bad;
    bare = !s.line.seenEq;
    for (int i = 0; i < 9; i++) begin
      if (s.line.argDec == ici_pkg::BAUD_TAB[i]) begin
        hit = 1'b1;
        bc = 4'(i);
      end
    end
    n.smpReq = 1'b0;
    n.logWr = 1'b0;
    n.rtcLoad = 1'b0;
    n.booted = 1'b1;
    if (s.txV && txReady) n.txV = 1'b0;
    // power-on sampling decided by the flag after reset release
    if (!s.booted && s.cfg.pwrOnRun) begin // R4 R5
      n.smp = ici_pkg::SMP_BUSY;
      n.smpReq = 1'b1;
    end
    // sampling engine
    case (s.smp)
      ici_pkg::SMP_BUSY: begin
        if (sampleDone) begin
          if (s.cfg.store) begin // R14
            n.logWr = 1'b1;
            n.logAddr = s.ptr;
            n.ptr = s.ptr + 1'b1; // R6
          end
          case (s.cfg.mode)
            ici_pkg::MODE_INTERVAL: begin // R2
              n.smp = ici_pkg::SMP_WAIT;
              n.tick = 32'h0;
              n.secs = 15'h0;
            end
            ici_pkg::MODE_CONT: n.smpReq = 1'b1; // R3
            default: n.smp = ici_pkg::SMP_IDLE; // R1
          endcase
        end
      end
      ici_pkg::SMP_WAIT: begin
        if (s.tick == TICKS - 1) begin
          n.tick = 32'h0;
          n.secs = s.secs + 1'b1;
          if (s.secs == s.cfg.intervalS - 1'b1) begin // R2
            n.smp = ici_pkg::SMP_BUSY;
            n.smpReq = 1'b1;
          end
        end else begin
          n.tick = s.tick + 1'b1;
        end
      end
      default: ;
    endcase
    // idle timer while awake
    if (s.awake) begin
      n.idleCnt = s.idleCnt + 1'b1;
      // a timeout held off by a character other than a terminator fires on the next quiet cycle
      if (s.idleCnt >= 36'(IDLE_CYC - 1) && !rxValid) begin // R9
        n.awake = 1'b0;
        n.line = '0;
      end
    end
    // bus write data phase
    if (s.wrPend) begin
      case (s.wrAddr)
        ici_pkg::REG_CFG: if (wc.baud < ici_pkg::BAUD_CNT) n.cfg = wc; // R11
        ici_pkg::REG_PRESS: n.refP = hwdata;
        default: ;
      endcase
    end
    // bus address phase
    n.wrPend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.wrPend = hwrite;
      n.wrAddr = haddr[7:0];
      n.rdata = 32'h0;
      if (!hwrite) begin
        case (haddr[7:0])
          ici_pkg::REG_CFG:   n.rdata = 32'(s.cfg);
          ici_pkg::REG_STAT:  n.rdata = 32'({s.smp, s.awake});
          ici_pkg::REG_PTR:   n.rdata = 32'(s.ptr);
          ici_pkg::REG_TALLY: n.rdata = 32'(s.tally);
          ici_pkg::REG_PRESS: n.rdata = s.refP;
          default:            n.rdata = 32'h0;
        endcase
      end
    end
    // serial characters
    if (rxValid) begin
      if (!s.awake) begin
        if (rxUp == ici_pkg::CH_CR) begin // R8
          n.awake = 1'b1;
          n.idleCnt = 36'h0;
        end
      end else if (rxUp == ici_pkg::CH_CR) begin // R23
        n.line = '0;
        n.idleCnt = 36'h0;
      end else if (s.line.lineLen == LINE_MAX) begin
        n.line.ovf = 1'b1; // R23
      end else begin
        n.line.lineLen = s.line.lineLen + 1'b1;
        if (!s.line.seenEq) begin
          if (rxUp == ici_pkg::CH_EQ) begin
            n.line.seenEq = 1'b1;
          end else begin
            n.line.keyLen = s.line.keyLen + 1'b1;
            n.line.keyTail = {s.line.keyTail[23:0], rxUp};
          end
        end else if (rxUp >= 8'h30 && rxUp <= 8'h39) begin
          n.line.argDec = 32'(s.line.argDec * 32'hA) + {28'h0, rxUp[3:0]};
          n.line.argBcd = {s.line.argBcd[51:0], rxUp[3:0]};
          n.line.digits = s.line.digits + 1'b1;
        end else if ((rxUp == ici_pkg::CH_YES || rxUp == ici_pkg::CH_NO)
                     && !s.line.seenYn) begin
          n.line.seenYn = 1'b1;
          n.line.yes = rxUp == ici_pkg::CH_YES;
        end else begin
          n.line.bad = 1'b1;
        end
      end
    end
    // command execution on the terminator
    if (lineEnd) begin // R7
      case (lineKey)
        ici_pkg::KW_ACQ_MODE:
          if (numOk && s.line.argDec >= 32'h1 && s.line.argDec <= 32'h3) begin
            n.cfg.mode = s.line.argDec[1:0];
          end else execErr = 1'b1;
        ici_pkg::KW_INTERVAL:
          if (numOk && s.line.argDec >= ici_pkg::INTERVAL_MIN
              && s.line.argDec <= ici_pkg::INTERVAL_MAX) begin
            n.cfg.intervalS = s.line.argDec[14:0];
          end else execErr = 1'b1;
        ici_pkg::KW_POWER_ON:
          if (ynOk) n.cfg.pwrOnRun = s.line.yes; // R4 R5
          else execErr = 1'b1;
        ici_pkg::KW_LOG_RESET:
          if (bare) n.ptr = '0; // R6
          else execErr = 1'b1;
        ici_pkg::KW_LAST_REC:
          if (numOk) n.ptr = s.line.argDec[ici_pkg::PTR_W-1:0]; // R15
          else execErr = 1'b1;
        ici_pkg::KW_CLOCK_SET:
          if (numOk && s.line.digits == ici_pkg::DATE_DIGITS) begin // R12
            n.rtc = s.line.argBcd;
            n.rtcLoad = 1'b1;
          end else execErr = 1'b1;
        ici_pkg::KW_SPEED:
          if (numOk && hit) n.cfg.baud = bc; // R11
          else execErr = 1'b1;
        ici_pkg::KW_SESSION_END:
          if (bare) n.awake = 1'b0; // R13
          else execErr = 1'b1;
        ici_pkg::KW_STORE:
          if (ynOk) n.cfg.store = s.line.yes; // R14
          else execErr = 1'b1;
        ici_pkg::KW_ENCODING:
          if (numOk && s.line.argDec <= 32'(ici_pkg::FMT_MAX)) begin // R16
            n.cfg.fmt = s.line.argDec[1:0];
          end else execErr = 1'b1;
        ici_pkg::KW_TIME_F:
          if (ynOk) n.cfg.timeF = s.line.yes; // R17
          else execErr = 1'b1;
        ici_pkg::KW_SAL_F:
          if (ynOk) n.cfg.salF = s.line.yes; // R18
          else execErr = 1'b1;
        ici_pkg::KW_SOUND_F:
          if (ynOk) n.cfg.svF = s.line.yes; // R19
          else execErr = 1'b1;
        ici_pkg::KW_DENS_F:
          if (ynOk) n.cfg.densF = s.line.yes; // R20
          else execErr = 1'b1;
        ici_pkg::KW_FIX_PRESS:
          if (numOk) n.refP = s.line.argDec; // R21
          else execErr = 1'b1;
        ici_pkg::KW_CFG_Q:     rpl = ici_pkg::RPL_CFG; // R22
        ici_pkg::KW_STATE_Q:   rpl = ici_pkg::RPL_STAT;
        ici_pkg::KW_STAT_DUMP: rpl = ici_pkg::RPL_STAT;
        ici_pkg::KW_COEF_Q:    rpl = ici_pkg::RPL_COEF;
        ici_pkg::KW_COEF_DUMP: rpl = ici_pkg::RPL_COEF;
        ici_pkg::KW_TALLY_Q:   rpl = ici_pkg::RPL_EVT;
        ici_pkg::KW_HW_Q:      rpl = ici_pkg::RPL_HW;
        ici_pkg::KW_TALLY_CLR:
          if (bare) n.tally = 16'h0; // R22
          else execErr = 1'b1;
        ici_pkg::KW_RUN:
          if (bare) begin
            n.smp = ici_pkg::SMP_BUSY;
            n.smpReq = 1'b1;
          end else execErr = 1'b1;
        ici_pkg::KW_HALT:
          if (bare) begin
            n.smp = ici_pkg::SMP_IDLE;
            n.smpReq = 1'b0;
          end else execErr = 1'b1;
        default: execErr = 1'b1; // R10
      endcase
      if (rpl != 8'h0 && !bare) begin
        execErr = 1'b1;
        rpl = 8'h0;
      end
      if (execErr) begin // R10
        n.tally = s.tally + 1'b1;
        n.txV = 1'b1;
        n.txD = ici_pkg::CH_ERR;
      end else if (rpl != 8'h0) begin
        n.txV = 1'b1;
        n.txD = rpl;
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s <= ST_RST;
    end else if (clkEn) begin
      s <= n;
    end
  end

  // outputs straight from the state register, except hresp which is tied to OKAY
  assign txValid     = s.txV;
  assign txData      = s.txD;
  assign sampleReq   = s.smpReq;
  assign logWrite    = s.logWr;
  assign logAddr     = s.logAddr;
  assign rtcLoad     = s.rtcLoad;
  assign rtcValue    = s.rtc;
  assign cfgOut      = s.cfg;
  assign refPressure = s.refP;
  assign awake       = s.awake;
  assign hreadyout   = s.busRdy;
  assign hresp       = 1'b0; // always OKAY
  assign hrdata      = s.rdata;

  // checks on the behaviour above
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  single_shot_a: assert property (clkEn && smpTaken && !lineEnd // R1
    && s.cfg.mode == ici_pkg::MODE_SINGLE |=> s.smp == ici_pkg::SMP_IDLE
    && !sampleReq) else $error("single mode kept sampling");
  interval_wait_a: assert property (clkEn && smpTaken && !lineEnd // R2
    && s.cfg.mode == ici_pkg::MODE_INTERVAL |=> s.smp == ici_pkg::SMP_WAIT
    && !sampleReq) else $error("interval mode did not wait");
  back_to_back_a: assert property (clkEn && smpTaken && !lineEnd // R3
    && s.cfg.mode == ici_pkg::MODE_CONT |=> sampleReq)
    else $error("continuous mode did not resample");
  log_reset_a: assert property (clkEn && lineEnd // R6
    && lineKey == ici_pkg::KW_LOG_RESET && !s.line.seenEq |=> s.ptr == '0)
    else $error("log pointer not cleared");
  wake_up_a: assert property (clkEn && rxValid && !s.awake // R8
    && rxUp == ici_pkg::CH_CR |=> awake) else $error("terminator did not wake");
  idle_sleep_a: assert property (clkEn && s.awake && !rxValid // R9
    && s.idleCnt == 36'(IDLE_CYC - 1) |=> !awake)
    else $error("idle timeout did not sleep");
  error_reply_a: assert property (clkEn && execErr // R10
    |=> txValid && txData == ici_pkg::CH_ERR) else $error("no error reply");
  speed_range_a: assert property (cfgOut.baud < ici_pkg::BAUD_CNT) // R11
    else $error("serial speed code out of range");
  session_end_a: assert property (clkEn && lineEnd // R13
    && lineKey == ici_pkg::KW_SESSION_END && !s.line.seenEq |=> !awake)
    else $error("session end did not sleep");
  store_gate_a: assert property (clkEn && smpTaken && !s.cfg.store // R14
    |=> !logWrite) else $error("sample stored with store flag off");

  interval_cov: cover property (s.smp == ici_pkg::SMP_WAIT ##1 sampleReq);
  error_cov: cover property (clkEn && execErr);
  sleep_cov: cover property (s.awake ##1 !s.awake);
  wake_cov: cover property (!s.awake ##1 s.awake);
endmodule
`default_nettype wire

// >>> verif/ici_host.sv
// host terminal model: sends command lines and takes reply bytes
`timescale 1ns/100ps
`default_nettype none
module ici_host (
  input  wire logic       mclk,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            txReady
);
  logic [7:0] lastReply;
  logic       pace;
  // one character per cycle, carriage return last
  task automatic sendLine(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge mclk);
      rxValid <= 1'b1;
      rxData  <= (i == s.len()) ? ici_pkg::CH_CR : s[i];
    end
    @(posedge mclk);
    rxValid <= 1'b0;
    rxData  <= ~rxData;
  endtask
  initial begin
    rxValid   = 1'b0;
    rxData    = 8'h00;
    txReady   = 1'b0;
    pace      = 1'b0;
    lastReply = 8'h00;
  end
  // sink is ready every other cycle, so replies must wait
  always @(posedge mclk) begin
    pace    <= ~pace;
    txReady <= pace;
    if (txValid && txReady)
      lastReply <= txData;
  end
endmodule
`default_nettype wire

// >>> verif/ici_top_bench.sv
// self-checking bench of the command interpreter
`timescale 1ns/100ps
`default_nettype none
module ici_top_bench;
  logic mclk, arst_n, clkEn, sampleDone, hsel, hwrite, rxValid, txReady;
  logic txValid, sampleReq, logWrite, rtcLoad, awake, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [7:0]  rxData, txData;
  logic [31:0] haddr, hwdata, hrdata, refPressure, rd, rs;
  logic [23:0] logAddr;
  logic [55:0] rtcValue;
  ici_pkg::ici_cfg_t cfgOut;
  int failures, check_count, reqCount, logCount, rtcCount, b1, b2;
  // query keywords; the two-letter ones are spelled as bytes
  string q[7] = '{"letcd", "letsd", "letcc", "letec", "lethd",
    string'(16'h6473), string'(16'h6463)};
  logic [7:0] e[7] = '{8'h43, 8'h53, 8'h4B, 8'h45, 8'h48, 8'h53, 8'h4B};
  string f[4] = '{"recordtime", "fieldtsal", "showutsv", "recorddensity"};
  localparam logic [28:0] CFG_RST = {15'h6, 4'h4, 4'h0, 2'h2, 2'h1, 2'h1};
  ici_top #(.IDLE_CYC(200), .TICKS(4)) u_ici_top (.mclk(mclk),
    .arst_n(arst_n), .clkEn(clkEn), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .sampleReq(sampleReq), .sampleDone(sampleDone), .logWrite(logWrite),
    .logAddr(logAddr), .rtcLoad(rtcLoad), .rtcValue(rtcValue),
    .cfgOut(cfgOut), .refPressure(refPressure), .awake(awake),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  ici_host u_ici_host (.mclk(mclk), .txValid(txValid), .txData(txData),
    .rxValid(rxValid), .rxData(rxData), .txReady(txReady));
  always #2.5 mclk = ~mclk;
  // sensor answers each request a cycle later; pulses are counted
  always @(posedge mclk) begin
    sampleDone <= sampleReq;
    if (sampleReq) reqCount++;
    if (logWrite) logCount++;
    if (rtcLoad) rtcCount++;
  end
  function automatic logic [31:0] nxtRnd(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // random letter case
  function automatic string mix(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rs = nxtRnd(rs);
      if (rs[0] && s[i] >= "a" && s[i] <= "z") s[i] = s[i] - 8'h20;
    end
    return s;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input string s);
    u_ici_host.sendLine(mix(s));
    repeat (8) @(posedge mclk);
  endtask
  task automatic run(input string m, input int n);
    cmd(m);
    b1 = reqCount;
    b2 = logCount;
    cmd("start");
    repeat (n) @(posedge mclk);
  endtask
  task automatic stop_test();
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    {mclk, arst_n, sampleDone, hsel, hwrite, htrans} = '0;
    {haddr, hwdata} = '0;
    clkEn = 1'b1;
    rs = 32'h4;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(cfgOut, CFG_RST);
    ahb(1'b0, 32'h14, 32'h0);
    chk({rd, awake, hresp}, 34'h0);
    cmd("x");
    chk({awake, u_ici_host.lastReply, reqCount}, {1'b1, 40'h0});
    for (int i = 0; i < 9; i++) begin
      cmd($sformatf("linerate=%0d", ici_pkg::BAUD_TAB[i]));
      chk(cfgOut.baud, i[3:0]);
    end
    cmd("linerate=700");
    chk({u_ici_host.lastReply, cfgOut.baud}, 12'h3F8);
    for (int i = 0; i < 7; i++) begin
      cmd("xyz");
      chk(u_ici_host.lastReply, ici_pkg::CH_ERR);
      cmd(q[i]);
      chk(u_ici_host.lastReply, e[i]);
    end
    cmd(string'({40{"z"}}));
    ahb(1'b0, {24'h0, ici_pkg::REG_TALLY}, 32'h0);
    chk({u_ici_host.lastReply, rd}, 40'h4B_00000008);
    cmd("zapetec");
    ahb(1'b0, {24'h0, ici_pkg::REG_TALLY}, 32'h0);
    chk(rd, 32'h0);
    cmd("walltime=01022024030405");
    chk({rtcValue, 8'(rtcCount)}, {56'h01022024030405, 8'h1});
    cmd("fixedbasepressure=123");
    chk(refPressure, 32'h7B);
    ahb(1'b1, {24'h0, ici_pkg::REG_PRESS}, 32'h55);
    ahb(1'b0, {24'h0, ici_pkg::REG_PRESS}, 32'h0);
    chk({rd, refPressure}, 64'h55_00000055);
    run("sensormode=1", 20);
    chk(reqCount - b1, 1);
    cmd("recordnumber=5");
    run("sensormode=3", 20);
    cmd("stop");
    ahb(1'b0, {24'h0, ici_pkg::REG_PTR}, 32'h0);
    chk(reqCount - b1 > 5, 1);
    chk({rd, logAddr}, {32'(5 + logCount - b2), 24'(4 + logCount - b2)});
    cmd("freelogging");
    ahb(1'b0, {24'h0, ici_pkg::REG_PTR}, 32'h0);
    chk(rd, 32'h0);
    run("writedata=n", 20);
    cmd("stop");
    chk(logCount - b2, 0);
    run("sensormode=2", 2);
    ahb(1'b0, {24'h0, ici_pkg::REG_STAT}, 32'h0);
    chk({rd[2:1], reqCount - b1 == 1}, 3'h5);
    repeat (30) @(posedge mclk);
    chk(reqCount - b1, 2);
    cmd("stop");
    for (int i = 0; i < 4; i++) begin
      cmd({f[i], "=y"});
      chk(cfgOut[6+i], 1'b1);
      cmd($sformatf("recordformat=%0d", 3 - i));
      chk(cfgOut.fmt, 3 - i);
    end
    cmd("gotorun=y");
    chk(cfgOut.pwrOnRun, 1'b1);
    cmd(string'(16'h7173));
    chk(awake, 1'b0);
    cmd("");
    // a frozen clock enable must hold the idle timer for 30 cycles
    clkEn <= 1'b0;
    repeat (30) @(posedge mclk);
    clkEn <= 1'b1;
    repeat (180) @(posedge mclk);
    chk(awake, 1'b1);
    repeat (30) @(posedge mclk);
    chk(awake, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
